/* File: lcdi2c_defines.svh */
`ifndef LCDI2C_DEFINES_SVH
`define LCDI2C_DEFINES_SVH
`define LCDI2C_ADDR_HI 5'h0F
`define LCDI2C_CHAR_RAM_DEPTH 128
`define LCDI2C_SPACE_CODE 8'h20
`define LCDI2C_CHAIN_BIT 7
`define LCDI2C_SEL_BIT 6
`define LCDI2C_FS_BW_BIT 4
`define LCDI2C_FS_LINES_BIT 3
`define LCDI2C_FS_FONT_BIT 2
`define LCDI2C_RST_BUS_WIDTH 1'h1
`define LCDI2C_RST_LINES 1'h0
`define LCDI2C_RST_FONT 1'h0
`define LCDI2C_RST_DISP_CTRL 3'h0
`define LCDI2C_RST_ENTRY_INC 1'h1
`define LCDI2C_RST_ENTRY_SHIFT 1'h0
`endif

/* File: lcdi2c_pkg.sv */
package lcdi2c_pkg;
   typedef enum logic [2:0] {
      LCDI2C_IDLE,
      LCDI2C_ADDR,
      LCDI2C_CTRL,
      LCDI2C_DATA,
      LCDI2C_IGNORE
   } lcdi2c_phase_t;
   typedef enum logic [1:0] {
      LCDI2C_INIT_CLEAR,
      LCDI2C_INIT_SET,
      LCDI2C_INIT_DONE
   } lcdi2c_init_t;
endpackage

/* File: lcdi2c_sync.sv */
`timescale 1ns/100ps
module lcdi2c_sync (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic async_in,
   output logic sync_out
);
   logic meta_ff;
   logic sync_ff;
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         meta_ff <= 1'b1;
         sync_ff <= 1'b1;
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end
   assign sync_out = sync_ff;
endmodule

/* File: lcdi2c_cond.sv */
`timescale 1ns/100ps
module lcdi2c_cond (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic start_out,
   output logic stop_out,
   output logic scl_rise_out,
   output logic scl_fall_out,
   output logic sda_out
);
   logic scl_d_ff;
   logic sda_d_ff;
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         scl_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end else begin
         scl_d_ff <= scl_in;
         sda_d_ff <= sda_in;
      end
   end
   // start and stop: data moves while clock stays high
   assign start_out = scl_in & scl_d_ff & sda_d_ff & ~sda_in;
   assign stop_out = scl_in & scl_d_ff & ~sda_d_ff & sda_in;
   assign scl_rise_out = scl_in & ~scl_d_ff;
   assign scl_fall_out = ~scl_in & scl_d_ff;
   assign sda_out = sda_d_ff;
endmodule

/* File: lcdi2c_top.sv */
`timescale 1ns/100ps
`include "lcdi2c_defines.svh"
// Function
// - data stable while clock high; one bit per pulse
// - falling data at high clock starts, rising stops
// - eight bits msb first, then acknowledge
// - addressed device acknowledges every byte
// - addresses 0111100 to 0111111 via straps
// - wrong address: ignore transfer, no acknowledge
// - write transfers only
// - control byte then data byte per word
// - cleared chain flag: data bytes until stop or repeated start
// - select one: write ram, step pointer up or down per entry mode
// - select zero: decode bytes as instructions
// - busy flag high during self initialization
// - initialization fills character ram with spaces
// - init: eight bit, one line, 5x8 font
// - init: increment by one, no shift
// - bus width bit picks eight or four bit
module lcdi2c_top (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic chip_sel_n_in,
   input wire logic addr_pin_lsb_in,
   input wire logic addr_pin_bit1_in,
   output logic sda_oe_out,
   output logic sda_drv_out,
   output logic busy_flag_out,
   output logic bus_width_sel_out,
   output logic lines_sel_out,
   output logic font_sel_out,
   output logic [2:0] disp_ctrl_out,
   output logic entry_inc_out,
   output logic entry_shift_out,
   output logic [6:0] ram_ptr_out,
   output logic ram_wr_out,
   output logic [7:0] ram_wdata_out,
   output logic [6:0] ram_waddr_out
);
   localparam int DEPTH = `LCDI2C_CHAR_RAM_DEPTH;
   logic scl_s;
   logic sda_s;
   logic csn_s;
   logic a0_s;
   logic a1_s;
   logic start_p;
   logic stop_p;
   logic scl_rise;
   logic scl_fall;
   logic sda_q;
   lcdi2c_pkg::lcdi2c_phase_t phase_ff;
   lcdi2c_pkg::lcdi2c_init_t init_ff;
   logic [7:0] shift_ff;
   logic [3:0] bit_cnt_ff;
   logic ack_slot_ff;
   logic data_only_ff;
   logic sel_ff;
   logic [6:0] init_addr_ff;
   logic [7:0] char_ram [0:DEPTH-1];
   logic byte_done;
   logic [7:0] nxt_byte;
   logic [7:0] hi_nib_ff;
   logic nib_half_ff;

   lcdi2c_sync u_scl (.clk_in(clk_in), .rst_n_in(rst_n_in), .async_in(scl_in), .sync_out(scl_s));
   lcdi2c_sync u_sda (.clk_in(clk_in), .rst_n_in(rst_n_in), .async_in(sda_in), .sync_out(sda_s));
   lcdi2c_sync u_csn (.clk_in(clk_in), .rst_n_in(rst_n_in), .async_in(chip_sel_n_in), .sync_out(csn_s));
   lcdi2c_sync u_a0 (.clk_in(clk_in), .rst_n_in(rst_n_in), .async_in(addr_pin_lsb_in), .sync_out(a0_s));
   lcdi2c_sync u_a1 (.clk_in(clk_in), .rst_n_in(rst_n_in), .async_in(addr_pin_bit1_in), .sync_out(a1_s));

   lcdi2c_cond u_cond (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .scl_in(scl_s),
      .sda_in(sda_s),
      .start_out(start_p),
      .stop_out(stop_p),
      .scl_rise_out(scl_rise),
      .scl_fall_out(scl_fall),
      .sda_out(sda_q)
   );

   // address match against fixed high bits and straps
   function automatic logic addr_hit(input logic [7:0] b, input logic s1, input logic s0);
      addr_hit = (b[7:3] == `LCDI2C_ADDR_HI) && (b[2] == s1) && (b[1] == s0);
   endfunction

   assign nxt_byte = {shift_ff[6:0], sda_q};
   // eighth bit sampled on clock rise, msb first
   assign byte_done = scl_rise && !ack_slot_ff && (bit_cnt_ff == 4'h7);

   // bit counter and shift register
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         shift_ff <= 8'h00;
         bit_cnt_ff <= 4'h0;
         ack_slot_ff <= 1'b0;
      end else if (start_p || stop_p) begin
         bit_cnt_ff <= 4'h0;
         ack_slot_ff <= 1'b0;
      end else if (scl_rise) begin
         if (ack_slot_ff) begin
            bit_cnt_ff <= 4'h0;
         end else begin
            shift_ff <= nxt_byte;
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
         end
      end else if (scl_fall && bit_cnt_ff == 4'h8) begin
         ack_slot_ff <= 1'b1;
         bit_cnt_ff <= 4'h0;
      end else if (scl_fall && ack_slot_ff && bit_cnt_ff == 4'h0) begin
         ack_slot_ff <= 1'b0;
      end
   end

   // transfer phase
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         phase_ff <= lcdi2c_pkg::LCDI2C_IDLE;
         data_only_ff <= 1'b0;
         sel_ff <= 1'b0;
      end else if (start_p) begin
         phase_ff <= csn_s ? lcdi2c_pkg::LCDI2C_IGNORE : lcdi2c_pkg::LCDI2C_ADDR;
         data_only_ff <= 1'b0;
      end else if (stop_p) begin
         phase_ff <= lcdi2c_pkg::LCDI2C_IDLE;
         data_only_ff <= 1'b0;
      end else if (byte_done) begin
         case (phase_ff)
            lcdi2c_pkg::LCDI2C_ADDR: begin
               // write with matching address only
               if (addr_hit(nxt_byte, a1_s, a0_s) && !nxt_byte[0]) begin
                  phase_ff <= lcdi2c_pkg::LCDI2C_CTRL;
               end else begin
                  phase_ff <= lcdi2c_pkg::LCDI2C_IGNORE;
               end
            end
            lcdi2c_pkg::LCDI2C_CTRL: begin
               sel_ff <= nxt_byte[`LCDI2C_SEL_BIT];
               data_only_ff <= ~nxt_byte[`LCDI2C_CHAIN_BIT];
               phase_ff <= lcdi2c_pkg::LCDI2C_DATA;
            end
            lcdi2c_pkg::LCDI2C_DATA: begin
               phase_ff <= data_only_ff ? lcdi2c_pkg::LCDI2C_DATA : lcdi2c_pkg::LCDI2C_CTRL;
            end
            default: begin
               phase_ff <= phase_ff;
            end
         endcase
      end
   end

   // acknowledge drive: low for whole ack clock, never for reads
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         sda_oe_out <= 1'b0;
      end else if (start_p || stop_p) begin
         sda_oe_out <= 1'b0;
      end else if (scl_fall && bit_cnt_ff == 4'h8) begin
         sda_oe_out <= (phase_ff == lcdi2c_pkg::LCDI2C_CTRL) || (phase_ff == lcdi2c_pkg::LCDI2C_DATA);
      end else if (scl_fall && ack_slot_ff) begin
         sda_oe_out <= 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      sda_drv_out <= 1'b0;
   end

   // data byte handling: ram writes, instruction decode, self init
   logic is_data_byte;
   assign is_data_byte = byte_done && phase_ff == lcdi2c_pkg::LCDI2C_DATA && init_ff == lcdi2c_pkg::LCDI2C_INIT_DONE;

   // four-bit mode pairs nibbles: high first, then low
   logic whole_byte;
   logic [7:0] cmd_byte;
   assign whole_byte = is_data_byte && (bus_width_sel_out || nib_half_ff);
   assign cmd_byte = bus_width_sel_out ? nxt_byte : {hi_nib_ff[3:0], nxt_byte[7:4]};

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         nib_half_ff <= 1'b0;
         hi_nib_ff <= 8'h00;
      end else if (start_p) begin
         nib_half_ff <= 1'b0;
      end else if (is_data_byte && !bus_width_sel_out) begin
         nib_half_ff <= ~nib_half_ff;
         hi_nib_ff <= {4'h0, nxt_byte[7:4]};
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         init_ff <= lcdi2c_pkg::LCDI2C_INIT_CLEAR;
         init_addr_ff <= 7'h00;
         busy_flag_out <= 1'b1;
         ram_wr_out <= 1'b0;
         ram_wdata_out <= 8'h00;
         ram_waddr_out <= 7'h00;
         ram_ptr_out <= 7'h00;
         bus_width_sel_out <= 1'b0;
         lines_sel_out <= 1'b0;
         font_sel_out <= 1'b0;
         disp_ctrl_out <= 3'h0;
         entry_inc_out <= 1'b0;
         entry_shift_out <= 1'b0;
      end else begin
         ram_wr_out <= 1'b0;
         case (init_ff)
            lcdi2c_pkg::LCDI2C_INIT_CLEAR: begin
               busy_flag_out <= 1'b1;
               ram_wr_out <= 1'b1;
               ram_waddr_out <= init_addr_ff;
               ram_wdata_out <= `LCDI2C_SPACE_CODE;
               char_ram[init_addr_ff] <= `LCDI2C_SPACE_CODE;
               init_addr_ff <= init_addr_ff + 7'h01;
               if (init_addr_ff == 7'(DEPTH - 1)) begin
                  init_ff <= lcdi2c_pkg::LCDI2C_INIT_SET;
               end
            end
            lcdi2c_pkg::LCDI2C_INIT_SET: begin
               bus_width_sel_out <= `LCDI2C_RST_BUS_WIDTH;
               lines_sel_out <= `LCDI2C_RST_LINES;
               font_sel_out <= `LCDI2C_RST_FONT;
               disp_ctrl_out <= `LCDI2C_RST_DISP_CTRL;
               entry_inc_out <= `LCDI2C_RST_ENTRY_INC;
               entry_shift_out <= `LCDI2C_RST_ENTRY_SHIFT;
               ram_ptr_out <= 7'h00;
               busy_flag_out <= 1'b0;
               init_ff <= lcdi2c_pkg::LCDI2C_INIT_DONE;
            end
            lcdi2c_pkg::LCDI2C_INIT_DONE: begin
               if (whole_byte && sel_ff) begin
                  char_ram[ram_ptr_out] <= cmd_byte;
                  ram_wr_out <= 1'b1;
                  ram_waddr_out <= ram_ptr_out;
                  ram_wdata_out <= cmd_byte;
                  ram_ptr_out <= entry_inc_out ? ram_ptr_out + 7'h01 : ram_ptr_out - 7'h01;
               end else if (whole_byte) begin
                  // instruction decode, highest set bit among 7, 5, 3, 2, 1, 0 picks the instruction; bits 6 and 4 are not decoded
                  if (cmd_byte[7]) begin
                     ram_ptr_out <= cmd_byte[6:0];
                  end else if (cmd_byte[5]) begin
                     bus_width_sel_out <= cmd_byte[`LCDI2C_FS_BW_BIT];
                     lines_sel_out <= cmd_byte[`LCDI2C_FS_LINES_BIT];
                     font_sel_out <= cmd_byte[`LCDI2C_FS_FONT_BIT];
                  end else if (cmd_byte[3]) begin
                     disp_ctrl_out <= cmd_byte[2:0];
                  end else if (cmd_byte[2]) begin
                     entry_inc_out <= cmd_byte[1];
                     entry_shift_out <= cmd_byte[0];
                  end else if (cmd_byte[1]) begin
                     ram_ptr_out <= 7'h00;
                  end else if (cmd_byte[0]) begin
                     init_addr_ff <= 7'h00;
                     ram_ptr_out <= 7'h00;
                     init_ff <= lcdi2c_pkg::LCDI2C_INIT_CLEAR;
                  end
               end
            end
            default: begin
               init_ff <= lcdi2c_pkg::LCDI2C_INIT_CLEAR;
            end
         endcase
      end
   end
endmodule

/* File: lcdi2c_assertions.sv */
`timescale 1ns/100ps
module lcdi2c_assertions (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic scl_in,
   input wire logic sda_oe_out,
   input wire logic sda_drv_out,
   input wire logic busy_flag_out,
   input wire logic bus_width_sel_out,
   input wire logic lines_sel_out,
   input wire logic font_sel_out,
   input wire logic [2:0] disp_ctrl_out,
   input wire logic entry_inc_out,
   input wire logic entry_shift_out,
   input wire logic [6:0] ram_ptr_out,
   input wire logic ram_wr_out,
   input wire logic [7:0] ram_wdata_out,
   input wire logic [6:0] ram_waddr_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   logic [6:0] wr_addr_ff;
   always_ff @(posedge clk_in) begin
      if (ram_wr_out) begin
         wr_addr_ff <= ram_waddr_out;
      end
   end
   sequence ack_clock_s;
      ##[1:40] $fell(scl_in);
   endsequence
   sequence init_end_s;
      $fell(busy_flag_out);
   endsequence
   busy_hold_a: assert property ($rose(rst_n_in) |-> busy_flag_out [*8])
      else $error("busy dropped early");
   busy_end_a: assert property ($rose(rst_n_in) |-> ##[1:300] !busy_flag_out)
      else $error("init never ends");
   init_fill_a: assert property (busy_flag_out && ram_wr_out |-> ram_wdata_out == 8'h20)
      else $error("init fill not space");
   init_func_a: assert property (init_end_s |-> ##[0:1] (bus_width_sel_out && !lines_sel_out && !font_sel_out))
      else $error("init function set wrong");
   init_disp_a: assert property (init_end_s |-> ##[0:1] disp_ctrl_out == 3'h0)
      else $error("init display control wrong");
   init_entry_a: assert property (init_end_s |-> ##[0:1] (entry_inc_out && !entry_shift_out))
      else $error("init entry mode wrong");
   ack_launch_a: assert property ($rose(sda_oe_out) |-> !scl_in)
      else $error("ack raised with clock high");
   ack_hold_a: assert property ($rose(sda_oe_out) |-> sda_oe_out throughout ack_clock_s)
      else $error("ack not held over clock");
   ack_release_a: assert property ($fell(sda_oe_out) |-> !scl_in)
      else $error("ack released with clock high");
   ack_level_a: assert property (sda_oe_out |-> !sda_drv_out)
      else $error("data driven high");
   ptr_step_a: assert property (ram_wr_out && !busy_flag_out |=> ##[0:1]
      ram_ptr_out == (entry_inc_out ? wr_addr_ff + 7'h01 : wr_addr_ff - 7'h01))
      else $error("pointer did not step");
endmodule

/* File: lcdi2c_master.sv */
`timescale 1ns/100ps
module lcdi2c_master (
   input wire logic clk_in,
   input wire logic sda_oe_in,
   output logic scl_out,
   output logic sda_line_out
);
   logic sda_drv;
   // pull-up: a released line reads high
   assign sda_line_out = sda_drv & ~sda_oe_in;
   initial begin
      scl_out = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   task automatic start_cond();
      tick(6);
      sda_drv <= 1'b1;
      tick(6);
      scl_out <= 1'b1;
      tick(7);
      sda_drv <= 1'b0;
      tick(6);
      scl_out <= 1'b0;
   endtask
   task automatic put_bit(input logic b, output logic s);
      tick(6);
      sda_drv <= b;
      tick(6);
      scl_out <= 1'b1;
      tick(7);
      s = sda_line_out;
      tick(6);
      scl_out <= 1'b0;
   endtask
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         put_bit(d[i], s);
      end
      put_bit(1'b1, s);
      ack = ~s;
   endtask
   task automatic stop_cond();
      tick(6);
      sda_drv <= 1'b0;
      tick(6);
      scl_out <= 1'b1;
      tick(7);
      sda_drv <= 1'b1;
      tick(12);
   endtask
endmodule

/* File: tb_lcd_i2c_write_slave.sv */
`timescale 1ns/100ps
module tb_lcd_i2c_write_slave;
   logic clk_in, rst_n_in, chip_sel_n_in, addr_pin_lsb_in, addr_pin_bit1_in, scl, sda_line;
   logic sda_oe_out, sda_drv_out, busy_flag_out, bus_width_sel_out, lines_sel_out, font_sel_out;
   logic entry_inc_out, entry_shift_out, ram_wr_out;
   logic [2:0] disp_ctrl_out;
   logic [6:0] ram_ptr_out, ram_waddr_out;
   logic [7:0] ram_wdata_out, cfg;
   logic [14:0] wr_q[$];
   int error_cnt = 0, num_checks = 0, cyc = 0;
   assign cfg = {bus_width_sel_out, lines_sel_out, font_sel_out, disp_ctrl_out, entry_inc_out, entry_shift_out};
   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end
   lcdi2c_master lcdi2c_master_i (.clk_in(clk_in), .sda_oe_in(sda_oe_out), .scl_out(scl), .sda_line_out(sda_line));
   lcdi2c_top lcdi2c_top_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda_line),
      .chip_sel_n_in(chip_sel_n_in), .addr_pin_lsb_in(addr_pin_lsb_in), .addr_pin_bit1_in(addr_pin_bit1_in),
      .sda_oe_out(sda_oe_out), .sda_drv_out(sda_drv_out), .busy_flag_out(busy_flag_out),
      .bus_width_sel_out(bus_width_sel_out), .lines_sel_out(lines_sel_out), .font_sel_out(font_sel_out),
      .disp_ctrl_out(disp_ctrl_out), .entry_inc_out(entry_inc_out), .entry_shift_out(entry_shift_out),
      .ram_ptr_out(ram_ptr_out), .ram_wr_out(ram_wr_out), .ram_wdata_out(ram_wdata_out),
      .ram_waddr_out(ram_waddr_out));
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (ram_wr_out === 1'b1) begin
         wr_q.push_back({ram_waddr_out, ram_wdata_out});
      end
      if (cyc == 40000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic check(input logic [14:0] got, input logic [14:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic [7:0] d, input logic exp_ack);
      logic a;
      lcdi2c_master_i.send_byte(d, a);
      check(15'(a), 15'(exp_ack));
   endtask
   task automatic t_init();
      int n;
      n = 0;
      while (busy_flag_out !== 1'b0 && n < 1000) begin
         @(posedge clk_in);
         n++;
      end
      check(15'(busy_flag_out), 15'h0000);
      check(15'(wr_q.size()), 15'h0080);
      foreach (wr_q[i]) check(15'(wr_q[i][7:0]), 15'h0020);
      check(15'(cfg), 15'h0082);
      $display("init test done");
   endtask
   task automatic t_ram();
      wr_q.delete();
      lcdi2c_master_i.start_cond();
      xfer(8'h78, 1'b1);
      xfer(8'h40, 1'b1);
      xfer(8'h41, 1'b1);
      xfer(8'h42, 1'b1);
      lcdi2c_master_i.stop_cond();
      check(15'(wr_q.size()), 15'h0002);
      check(wr_q[0], 15'h0041);
      check(wr_q[1], 15'h0142);
      check(15'(ram_ptr_out), 15'h0002);
      $display("ram test done");
   endtask
   task automatic t_cmd();
      wr_q.delete();
      addr_pin_lsb_in <= 1'b1;
      addr_pin_bit1_in <= 1'b1;
      repeat (6) @(posedge clk_in);
      lcdi2c_master_i.start_cond();
      xfer(8'h7E, 1'b1);
      xfer(8'h80, 1'b1);
      xfer(8'h90, 1'b1);
      xfer(8'hC0, 1'b1);
      xfer(8'h55, 1'b1);
      xfer(8'h00, 1'b1);
      xfer(8'h0C, 1'b1);
      xfer(8'h38, 1'b1);
      xfer(8'h05, 1'b1);
      lcdi2c_master_i.stop_cond();
      check(wr_q[0], 15'h1055);
      check(15'(cfg), 15'h00D1);
      check(15'(ram_ptr_out), 15'h0011);
      $display("command test done");
   endtask
   task automatic t_refuse();
      wr_q.delete();
      addr_pin_lsb_in <= 1'b0;
      addr_pin_bit1_in <= 1'b0;
      repeat (6) @(posedge clk_in);
      lcdi2c_master_i.start_cond();
      xfer(8'h7A, 1'b0);
      xfer(8'h40, 1'b0);
      lcdi2c_master_i.start_cond();
      xfer(8'h79, 1'b0);
      xfer(8'h40, 1'b0);
      lcdi2c_master_i.stop_cond();
      chip_sel_n_in <= 1'b1;
      lcdi2c_master_i.start_cond();
      xfer(8'h78, 1'b0);
      lcdi2c_master_i.stop_cond();
      chip_sel_n_in <= 1'b0;
      check(15'(wr_q.size()), 15'h0000);
      $display("refusal test done");
   endtask
   task automatic t_restart();
      wr_q.delete();
      lcdi2c_master_i.start_cond();
      xfer(8'h78, 1'b1);
      xfer(8'h40, 1'b1);
      lcdi2c_master_i.start_cond();
      xfer(8'h78, 1'b1);
      xfer(8'h40, 1'b1);
      xfer(8'h66, 1'b1);
      lcdi2c_master_i.stop_cond();
      check(15'(wr_q.size()), 15'h0001);
      check(wr_q[0], 15'h1166);
      check(15'(ram_ptr_out), 15'h0010);
      $display("restart test done");
   endtask
   task automatic t_modes();
      int n;
      wr_q.delete();
      lcdi2c_master_i.start_cond();
      xfer(8'h78, 1'b1);
      xfer(8'h00, 1'b1);
      xfer(8'h02, 1'b1);
      xfer(8'h20, 1'b1);
      xfer(8'h00, 1'b1);
      xfer(8'hE0, 1'b1);
      xfer(8'h30, 1'b1);
      xfer(8'h40, 1'b1);
      xfer(8'h06, 1'b1);
      check(15'(cfg), 15'h00BA);
      check(15'(ram_ptr_out), 15'h0000);
      xfer(8'h01, 1'b1);
      lcdi2c_master_i.stop_cond();
      check(15'(busy_flag_out), 15'h0001);
      n = 0;
      while (busy_flag_out !== 1'b0 && n < 1000) begin
         @(posedge clk_in);
         n++;
      end
      check(15'(busy_flag_out), 15'h0000);
      check(15'(wr_q.size()), 15'h0080);
      check(15'(cfg), 15'h0082);
      check(15'(ram_ptr_out), 15'h0000);
      $display("mode test done");
   endtask
   initial begin
      rst_n_in = 1'b0;
      chip_sel_n_in = 1'b0;
      addr_pin_lsb_in = 1'b0;
      addr_pin_bit1_in = 1'b0;
      repeat (12) @(posedge clk_in);
      rst_n_in <= 1'b1;
      t_init();
      t_ram();
      t_cmd();
      t_refuse();
      t_restart();
      t_modes();
      tally_and_finish();
   end
endmodule
bind lcdi2c_top lcdi2c_assertions lcdi2c_assertions_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .scl_in(scl_in),
   .sda_oe_out(sda_oe_out), .sda_drv_out(sda_drv_out), .busy_flag_out(busy_flag_out),
   .bus_width_sel_out(bus_width_sel_out), .lines_sel_out(lines_sel_out), .font_sel_out(font_sel_out),
   .disp_ctrl_out(disp_ctrl_out), .entry_inc_out(entry_inc_out), .entry_shift_out(entry_shift_out),
   .ram_ptr_out(ram_ptr_out), .ram_wr_out(ram_wr_out), .ram_wdata_out(ram_wdata_out),
   .ram_waddr_out(ram_waddr_out));
